//--- common/brd_map.vh
`ifndef BRD_MAP_VH
`define BRD_MAP_VH

// register byte offsets on the apb window
`define BRD_OFF_DIV_LOW 12'h000
`define BRD_OFF_DIV_HIGH 12'h004
`define BRD_OFF_TX_STATUS_CTRL 12'h008
`define BRD_OFF_BAUD_CTRL 12'h00c
`define BRD_OFF_RATE_STATUS 12'h010

// field positions
`define BRD_BIT_SYNC_MODE 4
`define BRD_BIT_HIGH_SPEED 2
`define BRD_BIT_WIDE_DIVISOR 3

// writable masks of the control registers
`define BRD_MASK_TX_STATUS_CTRL 8'h14
`define BRD_MASK_BAUD_CTRL 8'h08

// reset values
`define BRD_RST_DIV_LOW 8'h00
`define BRD_RST_DIV_HIGH 8'h00
`define BRD_RST_TX_STATUS_CTRL 8'h00
`define BRD_RST_BAUD_CTRL 8'h00

// prescale figures, stored as reload value (prescale minus one)
`define BRD_PRESCALE_64_RELOAD 6'h3f
`define BRD_PRESCALE_16_RELOAD 6'h0f
`define BRD_PRESCALE_4_RELOAD 6'h03

`endif

//--- rtl/brd_down_counter.v
`timescale 1ns/1ps
`default_nettype none

module brd_down_counter #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire reset_n,
  input wire clkEn,
  input wire restart,
  input wire step,
  input wire [WIDTH-1:0] reloadValue,
  output wire [WIDTH-1:0] count,
  output wire wrap
);

  reg [WIDTH-1:0] count_q;
  reg [WIDTH-1:0] count_d;

  // wrap is combinational so the next stage steps in the same cycle
  assign wrap = step & ~restart & (count_q == {WIDTH{1'b0}});
  assign count = count_q;

  always @* begin
    count_d = count_q;
    if (restart) begin
      count_d = reloadValue;
    end else if (wrap) begin
      count_d = reloadValue;
    end else if (step) begin
      count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      count_q <= {WIDTH{1'b0}};
    end else if (clkEn) begin
      count_q <= count_d;
    end
  end

endmodule

`default_nettype wire

//--- rtl/brd_rate_core.v
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "brd_map.vh"

module brd_rate_core #(
  parameter DIV_WIDTH = 16,
  parameter PRE_WIDTH = 6
) (
  input wire clk,
  input wire reset_n,
  input wire clkEn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg rateTick
);

  reg [7:0] divisorLow_q;
  reg [7:0] divisorHigh_q;
  reg [7:0] txStatusCtrl_q;
  reg [7:0] baudCtrl_q;
  reg initRestart_q;
  wire accessDone;
  wire wrLow;
  wire wrHigh;
  wire wrTx;
  wire wrBaud;
  wire syncMode;
  wire highSpeed;
  wire wideDivisor;
  wire [DIV_WIDTH-1:0] rateDivisor;
  wire [7:0] divisorLowNext;
  wire [7:0] divisorHighNext;
  wire [PRE_WIDTH-1:0] preReload;
  wire counterRestart;
  wire preWrap;
  wire divWrap;
  wire [PRE_WIDTH-1:0] preCount;
  wire [DIV_WIDTH-1:0] divCount;
  wire [31:0] rateStatus;

  function isMapped;
    input [11:0] addr;
    begin
      isMapped = (addr == `BRD_OFF_DIV_LOW) || (addr == `BRD_OFF_DIV_HIGH) ||
        (addr == `BRD_OFF_TX_STATUS_CTRL) || (addr == `BRD_OFF_BAUD_CTRL) ||
        (addr == `BRD_OFF_RATE_STATUS);
    end
  endfunction

  // prescale reload chosen from mode, width and speed bits
  function [PRE_WIDTH-1:0] prescaleSel;
    input sync;
    input wide;
    input fast;
    begin
      // sync ignores speed
      if (sync) begin
        prescaleSel = `BRD_PRESCALE_4_RELOAD;
      end else if (!wide && !fast) begin
        prescaleSel = `BRD_PRESCALE_64_RELOAD;
      end else if (wide && !fast) begin
        prescaleSel = `BRD_PRESCALE_16_RELOAD;
      end else if (!wide) begin
        prescaleSel = `BRD_PRESCALE_16_RELOAD;
      end else begin
        prescaleSel = `BRD_PRESCALE_4_RELOAD;
      end
    end
  endfunction

  // writes take effect in the cycle pready is high; read data is sampled in the wait cycle before
  assign accessDone = psel & penable & pready;
  assign wrLow = accessDone & pwrite & (paddr == `BRD_OFF_DIV_LOW);
  assign wrHigh = accessDone & pwrite & (paddr == `BRD_OFF_DIV_HIGH);
  assign wrTx = accessDone & pwrite & (paddr == `BRD_OFF_TX_STATUS_CTRL);
  assign wrBaud = accessDone & pwrite & (paddr == `BRD_OFF_BAUD_CTRL);

  assign syncMode = txStatusCtrl_q[`BRD_BIT_SYNC_MODE];
  assign highSpeed = txStatusCtrl_q[`BRD_BIT_HIGH_SPEED] & ~syncMode;
  assign wideDivisor = baudCtrl_q[`BRD_BIT_WIDE_DIVISOR];

  // high byte masked when narrow
  // reload sees the byte being written, not the stale one
  assign divisorLowNext = wrLow ? pwdata[7:0] : divisorLow_q;
  assign divisorHighNext = wrHigh ? pwdata[7:0] : divisorHigh_q;
  assign rateDivisor = wideDivisor ? {divisorHighNext, divisorLowNext} : {8'h00, divisorLowNext};

  assign preReload = prescaleSel(syncMode, wideDivisor, highSpeed);

  assign counterRestart = wrHigh | wrLow | initRestart_q;

  assign rateStatus = {10'h000, preCount, divCount};

  // mode bit changes take effect at the next reload, not at once
  brd_down_counter #(
    .WIDTH(PRE_WIDTH)
  ) u_prescale (
    .clk(clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .restart(counterRestart),
    .step(1'b1),
    .reloadValue(preReload),
    .count(preCount),
    .wrap(preWrap)
  );

  brd_down_counter #(
    .WIDTH(DIV_WIDTH)
  ) u_divisor (
    .clk(clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .restart(counterRestart),
    .step(preWrap),
    .reloadValue(rateDivisor),
    .count(divCount),
    .wrap(divWrap)
  );

  // counters load their reload values one cycle after reset release
  always @(posedge clk) begin
    if (!reset_n) begin
      initRestart_q <= 1'b1;
    end else if (clkEn) begin
      initRestart_q <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      divisorLow_q <= `BRD_RST_DIV_LOW;
      divisorHigh_q <= `BRD_RST_DIV_HIGH;
      txStatusCtrl_q <= `BRD_RST_TX_STATUS_CTRL;
      baudCtrl_q <= `BRD_RST_BAUD_CTRL;
    end else if (clkEn) begin
      if (wrLow) begin
        divisorLow_q <= pwdata[7:0];
      end
      if (wrHigh) begin
        divisorHigh_q <= pwdata[7:0];
      end
      // unrelated serial bits are not held here, so they read zero
      if (wrTx) begin
        txStatusCtrl_q <= pwdata[7:0] & `BRD_MASK_TX_STATUS_CTRL;
      end
      if (wrBaud) begin
        baudCtrl_q <= pwdata[7:0] & `BRD_MASK_BAUD_CTRL;
      end
    end
  end

  // one wait state: pready rises in the second access cycle
  always @(posedge clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (clkEn) begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~isMapped(paddr);
      prdata <= 32'h00000000;
      if (psel & penable & ~pready & ~pwrite) begin
        case (paddr)
          `BRD_OFF_DIV_LOW: begin
            prdata <= {24'h000000, divisorLow_q};
          end
          `BRD_OFF_DIV_HIGH: begin
            prdata <= {24'h000000, divisorHigh_q};
          end
          `BRD_OFF_TX_STATUS_CTRL: begin
            prdata <= {24'h000000, txStatusCtrl_q};
          end
          `BRD_OFF_BAUD_CTRL: begin
            prdata <= {24'h000000, baudCtrl_q};
          end
          `BRD_OFF_RATE_STATUS: begin
            prdata <= rateStatus;
          end
          default: begin
            prdata <= 32'h00000000;
          end
        endcase
      end
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      rateTick <= 1'b0;
    end else if (clkEn) begin
      rateTick <= divWrap;
    end
  end

endmodule

`default_nettype wire

//--- bench/brd_tick_sink.sv
`timescale 1ns/1ps
`default_nettype none
module brd_tick_sink (
  input wire logic clk,
  input wire logic tick,
  output var int gap
);
  int run = 0;
  // shift logic only cares about tick spacing
  always @(posedge clk) begin
    run <= tick ? 1 : run + 1;
    if (tick) begin
      gap <= run;
    end
  end
endmodule
`default_nettype wire

//--- bench/brd_rate_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "brd_map.vh"
module brd_rate_core_sva (
  input wire clk,
  input wire reset_n,
  input wire clkEn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rateTick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_ONE_WAIT: assert property (psel && penable && !pready && clkEn |=> pready)
    else $error("ready missing after wait state");
  AST_READY_PULSE: assert property (pready && clkEn |=> !pready)
    else $error("ready held too long");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_ERR_MAP: assert property (pready |-> pslverr == !(paddr == `BRD_OFF_DIV_LOW ||
    paddr == `BRD_OFF_DIV_HIGH || paddr == `BRD_OFF_TX_STATUS_CTRL ||
    paddr == `BRD_OFF_BAUD_CTRL || paddr == `BRD_OFF_RATE_STATUS))
    else $error("error response wrong");
  AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  AST_UPPER_ZERO: assert property (pready && paddr != 12'h010 |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_TICK_PULSE: assert property (rateTick && clkEn |=> !rateTick)
    else $error("tick held too long");
  AST_RESTART: assert property (
    pready && pwrite && clkEn && paddr < 12'h008 |=> !rateTick [*3])
    else $error("tick too soon after divisor write");
  AST_RESET: assert property (disable iff (1'b0) !reset_n |=> !pready && !rateTick)
    else $error("outputs active after reset");
  // a paused enable must not slip a tick
  AST_FREEZE: assert property (!clkEn |=> $stable(rateTick) && $stable(pready))
    else $error("state moved while paused");
  COV_ERR: cover property (pready && pslverr);
  COV_TICK: cover property (rateTick);
  COV_WRITE: cover property (pready && pwrite);
endmodule
bind brd_rate_core brd_rate_core_sva i_brd_rate_core_sva (.clk(clk), .reset_n(reset_n),
  .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rateTick(rateTick));
`default_nettype wire

//--- bench/brd_rate_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "brd_map.vh"
module brd_rate_core_tb;
  logic clk = 0, reset_n = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, rateTick;
  int bad_count = 0, checked = 0, gap, k, p, n;
  brd_rate_core i_brd_rate_core (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rateTick(rateTick));
  brd_tick_sink i_brd_tick_sink (.clk(clk), .tick(rateTick), .gap(gap));
  initial forever #10 clk = ~clk;
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one idle cycle after each transfer keeps psel from toggling twice in a step
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task wait_tick;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rateTick !== 1'b1 && k < 9000);
    if (rateTick !== 1'b1) begin
      bad_count++;
      $display("MISMATCH tick wait expected 1 seen 0");
    end
  endtask
  task wrap_up;
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #800000;
    bad_count++;
    wrap_up;
  end
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1;
    xfer(0, `BRD_OFF_RATE_STATUS, 0);
    chk("status after reset", {10'h000, `BRD_PRESCALE_64_RELOAD, 16'h0000}, rd);
    xfer(0, `BRD_OFF_DIV_HIGH, 0);
    chk("div high reset", `BRD_RST_DIV_HIGH, rd);
    chk("mapped error", 32'h0, {31'h0, err});
    xfer(1, `BRD_OFF_DIV_HIGH, 32'hffffffa5);
    xfer(0, `BRD_OFF_DIV_HIGH, 0);
    chk("div high", 32'ha5, rd);
    xfer(1, `BRD_OFF_TX_STATUS_CTRL, 32'hff);
    xfer(0, `BRD_OFF_TX_STATUS_CTRL, 0);
    chk("tx status ctrl", 32'h14, rd);
    xfer(1, `BRD_OFF_BAUD_CTRL, 32'hff);
    xfer(0, `BRD_OFF_BAUD_CTRL, 0);
    chk("baud ctrl", 32'h08, rd);
    xfer(0, 12'h020, 0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    // all sync, wide, fast codes; high byte 01 must be ignored when narrow
    for (int m = 0; m < 8; m++) begin
      p = m[2] ? 4 : m[1] ? (m[0] ? 4 : 16) : (m[0] ? 16 : 64);
      n = m[1] ? 258 : 2;
      xfer(1, `BRD_OFF_TX_STATUS_CTRL, 32'(((m & 4) << 2) | ((m & 1) << 2)));
      xfer(1, `BRD_OFF_BAUD_CTRL, 32'((m & 2) << 2));
      xfer(1, m[1] ? `BRD_OFF_DIV_LOW : `BRD_OFF_DIV_HIGH, m[1] ? 32'h02 : 32'h01);
      xfer(1, m[1] ? `BRD_OFF_DIV_HIGH : `BRD_OFF_DIV_LOW, m[1] ? 32'h01 : 32'h02);
      wait_tick;
      chk("first tick", p * (n + 1), k);
      wait_tick;
      @(posedge clk);
      chk("tick gap", p * (n + 1), gap);
    end
    wait_tick;
    clkEn <= 0;
    repeat (4) @(posedge clk);
    clkEn <= 1;
    wait_tick;
    @(posedge clk);
    // paused cycles stretch the gap in clock cycles
    chk("paused gap", 4 * 259 + 4, gap);
    wrap_up;
  end
endmodule
`default_nettype wire
